/* hw/ofa_addr_unit.sv */
// operand format and effective address unit of the cpu core
//
// Summary of operation
// [R01] handles bit, bcd, byte, word, longword operands
// [R02] bit ops touch one bit 0..7
// [R03] decimal adjust treats byte as two digits
// [R04] bcd upper digit 7:4, lower 3:0
// [R05] memory big-endian, msb at even address
// [R06] eight addressing modes supported
// [R07] displacement 16 or 32 added to register
// [R08] post-increment after, pre-decrement before access
// [R09] effective address truncated to 24 bits
// [R10] decoder recognises 65 instruction types
// [R11] byte, word, longword sizes for transfers
// [R12] register half splits into high/low bytes
`timescale 1ns/1ps
`include "ofa_map.svh"
module ofa_addr_unit
(
  input wire logic clk_sys, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic req, // start one operation, pulse
  input wire ofa_pkg::ofa_mode_type mode, // addressing mode
  input wire ofa_pkg::ofa_size_type size, // operand size
  input wire ofa_pkg::ofa_op_type op, // operand operation
  input wire logic [2:0] reg_idx, // long address register index
  input wire logic use_word_half, // select upper 16-bit half
  input wire logic use_high_byte, // select high byte of the half
  input wire logic [2:0] bit_pos, // bit position for bit ops
  input wire logic disp_long, // 32-bit displacement, else 16-bit
  input wire logic [31:0] ext_word, // displacement, absolute or immediate
  input wire logic [23:0] pc, // program counter
  input wire logic [31:0] mem_ind_ptr, // pointer read at memory indirect slot
  input wire logic [6:0] insn_type, // instruction type code
  input wire logic [31:0] operand_b, // second operand
  input wire logic carry_in, // carry flag for decimal adjust
  input wire logic half_carry_in, // half carry for decimal adjust
  output logic done, // result valid, pulse
  output logic [23:0] eff_addr, // effective address to bus
  output logic [31:0] result, // operand result
  output logic [31:0] mem_bytes, // result placed msb first
  output logic [3:0] mem_lanes, // byte lanes in use, msb at base
  output logic insn_valid // instruction type recognised
);
  // ------------------------------------------------------------
  // register memory access
  // ------------------------------------------------------------
  ofa_regfile_if rf();
  ofa_regfile u_regfile (.clk_sys(clk_sys), .resetn(resetn), .rf(rf.mem));

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC} ofa_state_type;
  ofa_state_type state_r;
  ofa_pkg::ofa_mode_type mode_r;
  ofa_pkg::ofa_size_type size_r;
  ofa_pkg::ofa_op_type op_r;
  logic [2:0] idx_r;
  logic half_r, hbyte_r, dlong_r;
  logic [2:0] bpos_r;
  logic [31:0] ext_r, opb_r, ptr_r;
  logic [23:0] pc_r;
  logic [6:0] itype_r;
  logic c_r, h_r;

  function automatic logic [31:0] size_step(input ofa_pkg::ofa_size_type s);
    case (s)
      ofa_pkg::OFA_SIZE_WORD: size_step = `OFA_STEP_WORD;
      ofa_pkg::OFA_SIZE_LONG: size_step = `OFA_STEP_LONG;
      default: size_step = `OFA_STEP_BYTE;
    endcase
  endfunction

  // pick the 8-bit register out of a 32-bit long register
  function automatic logic [7:0] pick_byte(input logic [31:0] r, input logic hw, input logic hb);
    logic [15:0] half;
    half = hw ? r[31:16] : r[15:0];
    pick_byte = hb ? half[15:8] : half[7:0]; // R12
  endfunction

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state_r <= ST_IDLE;
    else
      case (state_r)
        ST_IDLE: if (req) state_r <= ST_READ;
        ST_READ: state_r <= ST_EXEC;
        ST_EXEC: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_r <= ofa_pkg::OFA_MODE_REG_DIRECT;
      size_r <= ofa_pkg::OFA_SIZE_BYTE;
      op_r <= ofa_pkg::OFA_OP_PASS;
      idx_r <= 3'h0;
      half_r <= 1'b0;
      hbyte_r <= 1'b0;
      dlong_r <= 1'b0;
      bpos_r <= 3'h0;
      ext_r <= 32'h0;
      opb_r <= 32'h0;
      ptr_r <= 32'h0;
      pc_r <= 24'h0;
      itype_r <= 7'h0;
      c_r <= 1'b0;
      h_r <= 1'b0;
    end
    else if (state_r == ST_IDLE && req)
    begin
      mode_r <= mode;
      size_r <= size;
      op_r <= op;
      idx_r <= reg_idx;
      half_r <= use_word_half;
      hbyte_r <= use_high_byte;
      dlong_r <= disp_long;
      bpos_r <= bit_pos;
      ext_r <= ext_word;
      opb_r <= operand_b;
      ptr_r <= mem_ind_ptr;
      pc_r <= pc;
      itype_r <= insn_type;
      c_r <= carry_in;
      h_r <= half_carry_in;
    end
  end

  // ------------------------------------------------------------
  // effective address and pointer update
  // ------------------------------------------------------------
  logic [31:0] areg, ea_full, disp, step, rd_val;
  logic [7:0] byte_in, byte_out, adj;
  logic [31:0] res_nxt;

  assign areg = rf.rd_data;
  assign step = size_step(size_r);
  assign disp = dlong_r ? ext_r : {{16{ext_r[15]}}, ext_r[15:0]}; // R07

  always_comb
  begin
    case (mode_r) // R06
      ofa_pkg::OFA_MODE_REG_INDIRECT: ea_full = areg;
      ofa_pkg::OFA_MODE_DISP: ea_full = areg + disp; // R07
      ofa_pkg::OFA_MODE_INC_DEC: ea_full = op_r == ofa_pkg::OFA_OP_SUB ? areg - step : areg; // R08
      ofa_pkg::OFA_MODE_ABSOLUTE: ea_full = ext_r;
      ofa_pkg::OFA_MODE_PC_REL: ea_full = {8'h0, pc_r} + disp;
      ofa_pkg::OFA_MODE_MEM_INDIRECT: ea_full = ptr_r;
      default: ea_full = 32'h0;
    endcase
  end

  // in the inc/dec mode op SUB means pre-decrement, anything else post-increment
  assign rf.rd_idx = state_r == ST_IDLE ? reg_idx : idx_r;
  assign rf.wr_en = state_r == ST_EXEC && mode_r == ofa_pkg::OFA_MODE_INC_DEC; // R08
  assign rf.wr_idx = idx_r;
  assign rf.wr_data = op_r == ofa_pkg::OFA_OP_SUB ? areg - step : areg + step; // R08

  // ------------------------------------------------------------
  // operand formats
  // ------------------------------------------------------------
  assign rd_val = mode_r == ofa_pkg::OFA_MODE_IMMEDIATE ? ext_r : areg;
  assign byte_in = pick_byte(rd_val, half_r, hbyte_r); // R12

  // packed bcd: upper digit 7:4, lower 3:0
  always_comb
  begin
    adj = 8'h0;
    if (op_r == ofa_pkg::OFA_OP_DEC_ADJ_ADD) // R03
    begin
      if (h_r || byte_in[`OFA_BCD_LO_MSB:`OFA_BCD_LO_LSB] > 4'h9) adj[3:0] = 4'h6; // R04
      if (c_r || byte_in > 8'h99) adj[7:4] = 4'h6; // R04
    end
    else
    begin
      if (h_r) adj[3:0] = 4'h6;
      if (c_r) adj[7:4] = 4'h6;
    end
  end

  always_comb
  begin
    byte_out = byte_in;
    case (op_r)
      ofa_pkg::OFA_OP_BIT_SET: byte_out[bpos_r] = 1'b1; // R02
      ofa_pkg::OFA_OP_BIT_CLR: byte_out[bpos_r] = 1'b0; // R02
      ofa_pkg::OFA_OP_BIT_NOT: byte_out[bpos_r] = ~byte_in[bpos_r]; // R02
      ofa_pkg::OFA_OP_DEC_ADJ_ADD: byte_out = byte_in + adj; // R03
      ofa_pkg::OFA_OP_DEC_ADJ_SUB: byte_out = byte_in - adj; // R03
      default: byte_out = byte_in;
    endcase
  end

  always_comb
  begin
    logic [31:0] a;
    a = 32'h0;
    case (size_r) // R01 R11
      ofa_pkg::OFA_SIZE_LONG: a = rd_val;
      ofa_pkg::OFA_SIZE_WORD: a = {16'h0, half_r ? rd_val[31:16] : rd_val[15:0]};
      default: a = {24'h0, byte_in};
    endcase
    case (op_r)
      ofa_pkg::OFA_OP_ADD: res_nxt = a + opb_r;
      ofa_pkg::OFA_OP_SUB: res_nxt = mode_r == ofa_pkg::OFA_MODE_INC_DEC ? a : a - opb_r;
      ofa_pkg::OFA_OP_PASS: res_nxt = a;
      default: res_nxt = {24'h0, byte_out};
    endcase
    case (size_r) // R11
      ofa_pkg::OFA_SIZE_WORD: res_nxt = {16'h0, res_nxt[15:0]};
      ofa_pkg::OFA_SIZE_LONG: res_nxt = res_nxt;
      default: res_nxt = {24'h0, res_nxt[7:0]};
    endcase
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      done <= 1'b0;
      eff_addr <= 24'h0;
      result <= 32'h0;
      mem_bytes <= 32'h0;
      mem_lanes <= 4'h0;
      insn_valid <= 1'b0;
    end
    else
    begin
      done <= state_r == ST_EXEC;
      if (state_r == ST_EXEC)
      begin
        eff_addr <= ea_full[`OFA_ADDR_W-1:0]; // R09
        result <= res_nxt;
        // lane 3 is the base address; msb goes there
        case (size_r) // R05
          ofa_pkg::OFA_SIZE_LONG:
          begin
            mem_bytes <= res_nxt;
            mem_lanes <= 4'hf;
          end
          ofa_pkg::OFA_SIZE_WORD:
          begin
            mem_bytes <= {res_nxt[15:0], 16'h0};
            mem_lanes <= 4'hc;
          end
          default:
          begin
            mem_bytes <= {res_nxt[7:0], 24'h0};
            mem_lanes <= 4'h8;
          end
        endcase
        insn_valid <= itype_r < 7'(`OFA_NUM_INSN_TYPES); // R10
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_DONE_TIMING: assert property (@(posedge clk_sys) disable iff (!resetn) // R06
    (state_r == ST_IDLE && req) |-> ##3 done) else $error("done not three cycles after req");
  AST_ADDR_24: assert property (@(posedge clk_sys) disable iff (!resetn) // R09
    state_r == ST_EXEC |=> eff_addr == $past(ea_full[23:0])) else $error("address not truncated");
  AST_POSTINC: assert property (@(posedge clk_sys) disable iff (!resetn) // R08
    (state_r == ST_EXEC && mode_r == ofa_pkg::OFA_MODE_INC_DEC && op_r != ofa_pkg::OFA_OP_SUB)
    |-> rf.wr_data == areg + step && ea_full == areg) else $error("post-increment wrong");
  AST_PREDEC: assert property (@(posedge clk_sys) disable iff (!resetn) // R08
    (state_r == ST_EXEC && mode_r == ofa_pkg::OFA_MODE_INC_DEC && op_r == ofa_pkg::OFA_OP_SUB)
    |-> ea_full == rf.wr_data) else $error("pre-decrement wrong");
  AST_DISP16: assert property (@(posedge clk_sys) disable iff (!resetn) // R07
    (state_r == ST_EXEC && mode_r == ofa_pkg::OFA_MODE_DISP && !dlong_r)
    |-> ea_full == areg + {{16{ext_r[15]}}, ext_r[15:0]}) else $error("16-bit displacement wrong");
  AST_BIT_ONLY: assert property (@(posedge clk_sys) disable iff (!resetn) // R02
    (state_r == ST_EXEC && op_r == ofa_pkg::OFA_OP_BIT_SET) |-> byte_out == (byte_in | (8'h1 << bpos_r)))
    else $error("bit op touched other bits");
  AST_WORD_MSB_FIRST: assert property (@(posedge clk_sys) disable iff (!resetn) // R05
    (state_r == ST_EXEC && size_r == ofa_pkg::OFA_SIZE_WORD) |=> mem_bytes[31:24] == result[15:8])
    else $error("word not big-endian");
  AST_INSN_RANGE: assert property (@(posedge clk_sys) disable iff (!resetn) // R10
    (state_r == ST_EXEC && itype_r == 7'd65) |=> !insn_valid) else $error("type 65 accepted");
  AST_BCD_ADD: assert property (@(posedge clk_sys) disable iff (!resetn) // R03
    (state_r == ST_EXEC && op_r == ofa_pkg::OFA_OP_DEC_ADJ_ADD && !h_r && !c_r && byte_in == 8'h0a)
    |-> byte_out == 8'h10) else $error("decimal adjust wrong");
  // the lower digit wraps by ten whatever the flags say, so every bad lower digit reaches this
  AST_BCD_LOW_DIGIT: assert property (@(posedge clk_sys) disable iff (!resetn) // R04
    (state_r == ST_EXEC && op_r == ofa_pkg::OFA_OP_DEC_ADJ_ADD && byte_in[3:0] > 4'h9)
    |-> byte_out[3:0] == byte_in[3:0] - 4'ha) else $error("lower bcd digit not adjusted");
endmodule // ofa_addr_unit

/* hw/ofa_map.svh */
// constants of the operand format and address unit
`ifndef OFA_MAP_SVH
`define OFA_MAP_SVH
`define OFA_ADDR_W 24
`define OFA_REG_W 32
`define OFA_NUM_REGS 8
`define OFA_NUM_INSN_TYPES 65
`define OFA_STEP_BYTE 32'h00000001
`define OFA_STEP_WORD 32'h00000002
`define OFA_STEP_LONG 32'h00000004
`define OFA_BCD_HI_MSB 7
`define OFA_BCD_HI_LSB 4
`define OFA_BCD_LO_MSB 3
`define OFA_BCD_LO_LSB 0
`define OFA_REG_RESET 32'h00000000
`endif

/* hw/ofa_pkg.sv */
// types of the operand format and address unit
package ofa_pkg;
  typedef enum logic [2:0] {
    OFA_MODE_REG_DIRECT,
    OFA_MODE_REG_INDIRECT,
    OFA_MODE_DISP,
    OFA_MODE_INC_DEC,
    OFA_MODE_ABSOLUTE,
    OFA_MODE_IMMEDIATE,
    OFA_MODE_PC_REL,
    OFA_MODE_MEM_INDIRECT
  } ofa_mode_type;
  typedef enum logic [1:0] {
    OFA_SIZE_BYTE,
    OFA_SIZE_WORD,
    OFA_SIZE_LONG,
    OFA_SIZE_BIT
  } ofa_size_type;
  typedef enum logic [2:0] {
    OFA_OP_PASS,
    OFA_OP_ADD,
    OFA_OP_SUB,
    OFA_OP_BIT_SET,
    OFA_OP_BIT_CLR,
    OFA_OP_BIT_NOT,
    OFA_OP_DEC_ADJ_ADD,
    OFA_OP_DEC_ADJ_SUB
  } ofa_op_type;
endpackage

/* hw/ofa_regfile_if.sv */
// register file port bundle between the address unit and its register memory
`timescale 1ns/1ps
interface ofa_regfile_if;
  logic [2:0] rd_idx;
  logic [31:0] rd_data;
  logic wr_en;
  logic [2:0] wr_idx;
  logic [31:0] wr_data;
  modport core (output rd_idx, input rd_data, output wr_en, output wr_idx, output wr_data);
  modport mem (input rd_idx, output rd_data, input wr_en, input wr_idx, input wr_data);
endinterface

/* hw/ofa_regfile.sv */
// eight 32-bit long address registers, registered read
`timescale 1ns/1ps
`include "ofa_map.svh"
module ofa_regfile
(
  input wire logic clk_sys, // system clock
  input wire logic resetn, // async reset, active low
  ofa_regfile_if.mem rf // register port
);
  logic [31:0] regs_r [0:`OFA_NUM_REGS-1];
  logic [31:0] rd_data_r;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < `OFA_NUM_REGS; i++)
        regs_r[i] <= `OFA_REG_RESET;
    end
    else if (rf.wr_en)
      regs_r[rf.wr_idx] <= rf.wr_data;
  end

  // write-through so a pre-decremented pointer is seen on the next read
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rd_data_r <= `OFA_REG_RESET;
    else if (rf.wr_en && rf.wr_idx == rf.rd_idx)
      rd_data_r <= rf.wr_data;
    else
      rd_data_r <= regs_r[rf.rd_idx];
  end

  assign rf.rd_data = rd_data_r;
endmodule // ofa_regfile

/* tb/ofa_mem_model.sv */
// memory side model that answers the memory indirect pointer fetch
`timescale 1ns/1ps
module ofa_mem_model
(
  input wire logic req, // request strobe of the core
  input wire logic [31:0] ext_word, // slot address in the low byte
  output logic [31:0] mem_ind_ptr // pointer read from the slot
);
  logic [31:0] ptr;
  // upper byte is 8'hc3 xor the slot, nonzero except for slot c3, so a missing truncation shows
  assign ptr = {8'hc3 ^ ext_word[7:0], ext_word[7:0], ~ext_word[7:0], ext_word[7:0] ^ 8'h5a};
  // the bus is not held outside a request, so show the inverse
  assign mem_ind_ptr = req ? ptr : ~ptr;
endmodule // ofa_mem_model

/* tb/tb_top.sv */
// self-checking bench of the operand format and address unit
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, resetn, req, use_word_half, use_high_byte, disp_long, carry_in, half_carry_in, done, insn_valid;
  ofa_pkg::ofa_mode_type mode;
  ofa_pkg::ofa_size_type size;
  ofa_pkg::ofa_op_type op;
  ofa_pkg::ofa_op_type rop;
  logic [2:0] reg_idx, bit_pos;
  logic [6:0] insn_type;
  logic [23:0] pc, eff_addr;
  logic [31:0] ext_word, mem_ind_ptr, operand_b, result, mem_bytes;
  logic [3:0] mem_lanes;
  logic [31:0] regs_m [8];
  integer seed = 528;
  int fails = 0;
  int total_checks = 0;

  ofa_addr_unit u_dut
  (
    .clk_sys, .resetn, .req, .mode, .size, .op, .reg_idx, .use_word_half, .use_high_byte, .bit_pos, .disp_long,
    .ext_word, .pc, .mem_ind_ptr, .insn_type, .operand_b, .carry_in, .half_carry_in, .done, .eff_addr, .result,
    .mem_bytes, .mem_lanes, .insn_valid
  );
  ofa_mem_model u_mem
  (
    .req, .ext_word, .mem_ind_ptr
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // --------------------------------------------------------
  // checking helpers
  // --------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [31:0] fit(input logic [31:0] x, input ofa_pkg::ofa_size_type s);
    if (s == ofa_pkg::OFA_SIZE_LONG)
      return x;
    return (s == ofa_pkg::OFA_SIZE_WORD) ? {16'h0000, x[15:0]} : {24'h000000, x[7:0]};
  endfunction

  // subtract adjust looks only at the flags, add also at the digits
  function automatic logic [7:0] dec_fix(input logic [7:0] b, input logic c, input logic h, input logic sub);
    logic [7:0] adj;
    adj = 8'h00;
    if (h || (!sub && b[3:0] > 4'h9))
      adj[3:0] = 4'h6;
    if (c || (!sub && b > 8'h99))
      adj[7:4] = 4'h6;
    return sub ? b - adj : b + adj;
  endfunction

  function automatic ofa_pkg::ofa_size_type size_for(input ofa_pkg::ofa_op_type o, input logic [1:0] x);
    if (o >= ofa_pkg::OFA_OP_BIT_SET && o <= ofa_pkg::OFA_OP_BIT_NOT)
      return ofa_pkg::OFA_SIZE_BIT;
    if (o >= ofa_pkg::OFA_OP_DEC_ADJ_ADD)
      return ofa_pkg::OFA_SIZE_BYTE;
    return (x == 2'd3) ? ofa_pkg::OFA_SIZE_LONG : ofa_pkg::ofa_size_type'(x);
  endfunction

  task automatic clear_model();
    foreach (regs_m[i])
      regs_m[i] = 32'h00000000;
  endtask

  // one operation; bz keeps req up into the busy cycle to be refused
  task automatic issue(input ofa_pkg::ofa_mode_type m, input ofa_pkg::ofa_size_type s, input ofa_pkg::ofa_op_type o,
                       input logic [2:0] r, input logic [31:0] ew, input logic [6:0] it, input logic bz);
    logic wh, hb, dl, c, h, pre;
    logic [2:0] bp;
    logic [31:0] v, src, opd, ob, ea, res, st;
    logic [23:0] p;
    int n;
    {wh, hb, dl, c, h, bp} = 8'($random(seed));
    ob = $random(seed);
    p = 24'($random(seed));
    v = regs_m[r];
    src = (m == ofa_pkg::OFA_MODE_IMMEDIATE) ? ew : v;
    st = (s == ofa_pkg::OFA_SIZE_LONG) ? 4 : (s == ofa_pkg::OFA_SIZE_WORD) ? 2 : 1;
    pre = (m == ofa_pkg::OFA_MODE_INC_DEC) && (o == ofa_pkg::OFA_OP_SUB);
    @(posedge clk_sys);
    req <= 1'b1;
    mode <= m;
    size <= s;
    op <= o;
    {reg_idx, ext_word, insn_type, operand_b} <= {r, ew, it, ob};
    {use_word_half, use_high_byte, disp_long, carry_in, half_carry_in, bit_pos} <= {wh, hb, dl, c, h, bp};
    pc <= p;
    @(posedge clk_sys);
    req <= bz;
    ext_word <= ew ^ {32{bz}};
    n = 0;
    #1;
    while (done !== 1'b1)
    begin
      if (n == 8)
      begin
        fails++;
        $display("unexpected at %0t: no completion", $time);
        tally_and_finish();
      end
      @(posedge clk_sys);
      req <= 1'b0;
      #1;
      n++;
    end
    // done is seen two edges after the accepting edge, i.e. in cycle 3 counting the req cycle as 0
    chk(32'(n), 32'd2, "latency");
    chk(32'(insn_valid), 32'(it < 7'd65), "type valid");
    chk(32'(mem_lanes), (st == 4) ? 32'hf : (st == 2) ? 32'hc : 32'h8, "lanes");
    case (m)
      ofa_pkg::OFA_MODE_REG_INDIRECT: ea = v;
      ofa_pkg::OFA_MODE_DISP: ea = v + (dl ? ew : {{16{ew[15]}}, ew[15:0]});
      ofa_pkg::OFA_MODE_INC_DEC: ea = pre ? v - st : v;
      ofa_pkg::OFA_MODE_ABSOLUTE: ea = ew;
      ofa_pkg::OFA_MODE_MEM_INDIRECT: ea = {8'h00, ew[7:0], ~ew[7:0], ew[7:0] ^ 8'h5a};
      ofa_pkg::OFA_MODE_PC_REL: ea = {8'h00, p} + (dl ? ew : {{16{ew[15]}}, ew[15:0]});
      default: ea = 32'h00000000;
    endcase
    chk(32'(eff_addr), {8'h00, ea[23:0]}, "address");
    if (m == ofa_pkg::OFA_MODE_INC_DEC)
      regs_m[r] = pre ? v - st : v + st;
    if (m == ofa_pkg::OFA_MODE_REG_DIRECT || m == ofa_pkg::OFA_MODE_IMMEDIATE)
    begin
      opd = fit(src >> ((s == ofa_pkg::OFA_SIZE_LONG) ? 0 : (wh ? 16 : 0) + ((hb && st == 1) ? 8 : 0)), s);
      case (o)
        ofa_pkg::OFA_OP_ADD: res = fit(opd + ob, s);
        ofa_pkg::OFA_OP_SUB: res = fit(opd - ob, s);
        ofa_pkg::OFA_OP_BIT_SET: res = opd | (32'h1 << bp);
        ofa_pkg::OFA_OP_BIT_CLR: res = opd & ~(32'h1 << bp);
        ofa_pkg::OFA_OP_BIT_NOT: res = opd ^ (32'h1 << bp);
        ofa_pkg::OFA_OP_DEC_ADJ_ADD: res = {24'h000000, dec_fix(opd[7:0], c, h, 1'b0)};
        ofa_pkg::OFA_OP_DEC_ADJ_SUB: res = {24'h000000, dec_fix(opd[7:0], c, h, 1'b1)};
        default: res = opd;
      endcase
      chk(result, res, "result");
      chk(mem_bytes, res << (32 - 8 * st), "lane data");
    end
    if (bz)
      repeat (4)
      begin
        @(posedge clk_sys);
        #1;
        chk(32'(done), 32'h0, "refused request");
      end
  endtask

  // --------------------------------------------------------
  // main sequence
  // --------------------------------------------------------
  initial
  begin
    {resetn, req, use_word_half, use_high_byte, disp_long, carry_in, half_carry_in} = 7'h00;
    mode = ofa_pkg::OFA_MODE_REG_DIRECT;
    size = ofa_pkg::OFA_SIZE_BYTE;
    op = ofa_pkg::OFA_OP_PASS;
    {reg_idx, bit_pos, insn_type, pc, ext_word, operand_b} = '0;
    clear_model();
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    issue(ofa_pkg::OFA_MODE_INC_DEC, ofa_pkg::OFA_SIZE_LONG, ofa_pkg::OFA_OP_SUB, 3'd1, 32'h0, 7'd0, 1'b0);
    issue(ofa_pkg::OFA_MODE_INC_DEC, ofa_pkg::OFA_SIZE_BYTE, ofa_pkg::OFA_OP_SUB, 3'd2, 32'h0, 7'd64, 1'b0);
    issue(ofa_pkg::OFA_MODE_INC_DEC, ofa_pkg::OFA_SIZE_WORD, ofa_pkg::OFA_OP_PASS, 3'd2, 32'h0, 7'd65, 1'b0);
    issue(ofa_pkg::OFA_MODE_DISP, ofa_pkg::OFA_SIZE_WORD, ofa_pkg::OFA_OP_PASS, 3'd1, 32'h8000, 7'd127, 1'b0);
    $display("test corner done");
    for (int i = 0; i < 8; i++)
      issue(ofa_pkg::ofa_mode_type'(i), ofa_pkg::OFA_SIZE_LONG, ofa_pkg::OFA_OP_PASS, 3'(i), $random(seed),
            7'(60 + i), 1'b0);
    for (int i = 0; i < 8; i++)
      issue(ofa_pkg::OFA_MODE_REG_DIRECT, size_for(ofa_pkg::ofa_op_type'(i), 2'(i)), ofa_pkg::ofa_op_type'(i),
            3'd1, 32'h0, 7'd1, 1'b0);
    for (int i = 0; i < 8; i++)
      issue(ofa_pkg::OFA_MODE_IMMEDIATE, ofa_pkg::OFA_SIZE_BYTE, ofa_pkg::OFA_OP_DEC_ADJ_ADD, 3'd0, 32'h0a0a0a0a,
            7'd2, 1'b0);
    $display("test modes and ops done");
    for (int i = 0; i < 150; i++)
    begin
      rop = ofa_pkg::ofa_op_type'($random(seed));
      issue(ofa_pkg::ofa_mode_type'($random(seed)), size_for(rop, 2'($random(seed))), rop, 3'($random(seed)),
            $random(seed), 7'($random(seed)), 1'b0);
    end
    $display("test random done");
    issue(ofa_pkg::OFA_MODE_ABSOLUTE, ofa_pkg::OFA_SIZE_WORD, ofa_pkg::OFA_OP_PASS, 3'd0, 32'h123456, 7'd3, 1'b1);
    $display("test busy done");
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({done, insn_valid, mem_lanes, eff_addr}, 32'h0, "outputs in reset");
    chk(result | mem_bytes, 32'h0, "data in reset");
    @(posedge clk_sys);
    resetn <= 1'b1;
    clear_model();
    issue(ofa_pkg::OFA_MODE_INC_DEC, ofa_pkg::OFA_SIZE_WORD, ofa_pkg::OFA_OP_ADD, 3'd1, 32'h0, 7'd9, 1'b0);
    $display("test reset done");
    tally_and_finish();
  end
endmodule // tb_top
